/* File: tppwm_pkg.sv */
// Package with register map, field positions and reset values of the three-phase PWM block.
package tppwm_pkg;

	// Register byte addresses.
	localparam logic [31:0] ADDR_CONTROL   = 32'hfffffc00;
	localparam logic [31:0] ADDR_STATUS    = 32'hfffffc04;
	localparam logic [31:0] ADDR_PERIOD    = 32'hfffffc08;
	localparam logic [31:0] ADDR_DEADTIME  = 32'hfffffc0c;
	localparam logic [31:0] ADDR_CHOPCFG   = 32'hfffffc10;
	localparam logic [31:0] ADDR_DUTY_A    = 32'hfffffc14;
	localparam logic [31:0] ADDR_DUTY_B    = 32'hfffffc18;
	localparam logic [31:0] ADDR_DUTY_C    = 32'hfffffc1c;
	localparam logic [31:0] ADDR_OUTCTRL   = 32'hfffffc20;
	localparam logic [31:0] ADDR_SYNCWIDTH = 32'hfffffc24;

	// Control register field positions and writable mask.
	localparam int CTL_ENABLE     = 0;
	localparam int CTL_SYNC_EN    = 1;
	localparam int CTL_DOUBLE     = 2;
	localparam int CTL_EXT_TIMING = 3;
	localparam int CTL_SRC_SEL    = 4;
	localparam logic [15:0] CTL_MASK = 16'h001f;

	// Status register field positions.
	localparam int STA_HALF      = 0;
	localparam int STA_TRIP_PIN  = 3;
	localparam int STA_TRIP_FLAG = 8;
	localparam int STA_SYNC_FLAG = 9;

	// Chop configuration field positions and mask.
	localparam int CFG_HI_CHOP = 8;
	localparam int CFG_LO_CHOP = 9;
	localparam logic [15:0] CFG_MASK = 16'h03ff;

	// Output control: swap bits 8..6, disable bits 5..0.
	localparam int OUT_SWAP_LSB = 6;
	localparam logic [15:0] OUT_MASK = 16'h01ff;

	// Masks for the narrow value registers.
	localparam logic [15:0] TEN_BIT_MASK = 16'h03ff;
	localparam logic [15:0] REG_RESET    = 16'h0000;

	// Chop carrier is four core cycles per step of the period value.
	localparam int CHOP_MULT = 4;

	// Counting direction of the center-aligned period timer.
	typedef enum logic [0:0] {
		TPPWM_DOWN = 1'b0,
		TPPWM_UP   = 1'b1
	} tppwm_dir_e;

	// Register bus request.
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tppwm_bus_s;

endpackage : tppwm_pkg

/* File: tppwm_core.sv */
// Register interface and output stage of a three-phase center-aligned PWM controller.
// How it works
// RL1: Control bit 0 enables PWM; a fault trip clears it automatically.
// RL2: Control bit 1 enables the synchronisation function.
// RL3: Control bit 2 selects double update, also latching at mid-cycle.
// RL4: Control bit 3 marks external sync synchronous; cleared means resynchronise.
// RL5: Control bit 4 chooses external sync input over internal sync.
// RL6: Status bit 9 is the sync flag; writing 1 clears it.
// RL7: Status bit 8 is the trip flag; writing 1 clears it.
// RL8: Status bit 3 returns the raw trip pin level.
// RL9: Status bit 0 is 1 counting down, 0 counting up.
// RL10: Chop config bits 9 and 8 chop low and high sides independently.
// RL11: Chop config bits 7:0 hold the unsigned chop period value.
// RL12: Chop carrier period is four times value plus one core cycles.
// RL13: Output control bits 8,7,6 enable swap for pairs 0,1,2.
// RL14: Swap routes the high-side signal to low pin and back.
// RL15: Output control bits 5..0 disable 0L,0H,1L,1H,2L,2H.
// RL16: Disable applies after swap and holds the output off.
// RL17: Output control is latched on sync, also mid-cycle in double mode.
// RL18: Period register holds an unsigned 16-bit switching period.
// RL19: Dead time register holds an unsigned 10-bit value.
// RL20: Three duty registers hold one duty value per phase.
// RL21: Sync width register holds an unsigned 10-bit pulse width.
// RL22: Reserved bits read zero and ignore writes.
// RL23: Sync flag sets on each sync pulse; trip flag on trip shutdown.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

module tppwm_core (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Register port.
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	// Pins.
	input  wire logic        trip_n_in,
	input  wire logic        ext_sync_in,
	output logic       [5:0] gate_out,
	output logic             sync_out
);

	// All state of the block in one record.
	typedef struct packed {
		logic [15:0] control;
		logic [15:0] period;
		logic [15:0] dead;
		logic [15:0] chopcfg;
		logic [15:0] duty_a;
		logic [15:0] duty_b;
		logic [15:0] duty_c;
		logic [15:0] outctl;
		logic [15:0] outctl_act;
		logic [15:0] swidth;
		logic        sync_flag;
		logic        trip_flag;
		logic [15:0] timer;
		tppwm_pkg::tppwm_dir_e dir;
		logic [9:0]  sync_cnt;
		logic        sync_pulse;
		logic [9:0]  chop_cnt;
		logic        chop_clk;
		logic [1:0]  trip_sy;
		logic [1:0]  ext_sy;
		logic        ext_q;
		logic [31:0] rdata;
		logic [5:0]  gate;
	} tppwm_state_s;

	tppwm_state_s st;
	tppwm_state_s next_st;
	tppwm_pkg::tppwm_bus_s bus;

	// Pack the register port into one carrier.
	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// Read decode, used for read data; reserved bits come back as zero.
	function automatic logic [15:0] read_reg(input tppwm_state_s s, input logic [31:0] a);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			tppwm_pkg::ADDR_CONTROL:   v = s.control;
			tppwm_pkg::ADDR_STATUS: begin
				v[tppwm_pkg::STA_SYNC_FLAG] = s.sync_flag; // RL6
				v[tppwm_pkg::STA_TRIP_FLAG] = s.trip_flag; // RL7
				v[tppwm_pkg::STA_TRIP_PIN]  = s.trip_sy[1]; // RL8
				v[tppwm_pkg::STA_HALF]      = (s.dir == tppwm_pkg::TPPWM_DOWN); // RL9
			end
			tppwm_pkg::ADDR_PERIOD:    v = s.period;
			tppwm_pkg::ADDR_DEADTIME:  v = s.dead;
			tppwm_pkg::ADDR_CHOPCFG:   v = s.chopcfg;
			tppwm_pkg::ADDR_DUTY_A:    v = s.duty_a;
			tppwm_pkg::ADDR_DUTY_B:    v = s.duty_b;
			tppwm_pkg::ADDR_DUTY_C:    v = s.duty_c;
			tppwm_pkg::ADDR_OUTCTRL:   v = s.outctl;
			tppwm_pkg::ADDR_SYNCWIDTH: v = s.swidth;
			default:                   v = 16'h0000;
		endcase
		return v;
	endfunction : read_reg

	// Raw timing-unit levels for one phase: high side on when the timer is below duty.
	// Dead time is taken off both edges, so the two sides of a leg never overlap.
	function automatic logic [1:0] phase_raw(input logic [15:0] tmr, input logic [15:0] duty,
		input logic [15:0] dt);
		logic [1:0] p;
		logic [16:0] lo_edge;
		lo_edge = {1'b0, duty} + {1'b0, dt};
		p[1] = ({1'b0, tmr} + {1'b0, dt}) < {1'b0, duty};
		p[0] = {1'b0, tmr} >= lo_edge;
		return p;
	endfunction : phase_raw

	logic        tripped;
	logic        ext_level;
	logic        ext_rise;
	logic        boundary;
	logic        latch_now;
	logic [47:0] duties;
	logic [5:0]  raw;
	logic [5:0]  routed;
	logic [9:0]  chop_limit;

	// The trip pin is synchronised; a low level shuts the outputs down.
	// The two flops cost two cycles of reaction, but a metastable level never
	// reaches the enable, the flag and all six gates with different values.
	assign tripped    = ~st.trip_sy[1];
	assign ext_level  = st.control[tppwm_pkg::CTL_EXT_TIMING] ? ext_sync_in : st.ext_sy[1]; // RL4
	assign ext_rise   = ext_level & ~st.ext_q;
	assign boundary   = st.control[tppwm_pkg::CTL_SRC_SEL] ? ext_rise : // RL5
		(st.dir == tppwm_pkg::TPPWM_UP && st.timer >= st.period);
	assign latch_now  = boundary | (st.control[tppwm_pkg::CTL_DOUBLE] & // RL3
		st.dir == tppwm_pkg::TPPWM_DOWN & st.timer == 16'h0000);
	assign duties     = {st.duty_c, st.duty_b, st.duty_a}; // RL20
	// Carrier period is four times (value plus one): half period is twice that.
	assign chop_limit = 10'((tppwm_pkg::CHOP_MULT / 2) * (st.chopcfg[7:0] + 10'd1) - 1); // RL12

	// Per-phase swap and disable. Gate index 2p is the low side of phase p and
	// index 2p+1 its high side, so gate_out reads {2H,2L,1H,1L,0H,0L}.
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_phase
			logic [1:0] r;
			logic       swp;
			assign r   = phase_raw(st.timer, duties[16*gp +: 16], st.dead); // RL19
			assign raw[2*gp +: 2] = r;
			assign swp = st.outctl_act[tppwm_pkg::OUT_SWAP_LSB + 2 - gp]; // RL13
			// Swapped pair: high-side signal drives the low pin and back.
			assign routed[2*gp]     = swp ? r[1] : r[0]; // RL14
			assign routed[2*gp + 1] = swp ? r[0] : r[1]; // RL14
		end
	endgenerate

	// Next-state logic: registers, timer, sync, chopping and output gating.
	always_comb begin
		logic [15:0] w;
		logic [5:0]  g;
		logic [5:0]  dis;
		next_st = st;
		w = bus.wdata[15:0];
		g = 6'h00;
		dis = 6'h00;
		next_st.trip_sy = {st.trip_sy[0], trip_n_in};
		next_st.ext_sy  = {st.ext_sy[0], ext_sync_in};
		next_st.ext_q   = ext_level;
		next_st.rdata   = bus.rd ? {16'h0000, read_reg(st, bus.addr)} : 32'h0000_0000;
		// Register writes; reserved bits are masked off.
		if (bus.wr) begin
			unique case (bus.addr)
				tppwm_pkg::ADDR_CONTROL:   next_st.control = w & tppwm_pkg::CTL_MASK; // RL22
				tppwm_pkg::ADDR_PERIOD:    next_st.period  = w; // RL18
				tppwm_pkg::ADDR_DEADTIME:  next_st.dead    = w & tppwm_pkg::TEN_BIT_MASK; // RL19
				tppwm_pkg::ADDR_CHOPCFG:   next_st.chopcfg = w & tppwm_pkg::CFG_MASK; // RL11
				tppwm_pkg::ADDR_DUTY_A:    next_st.duty_a  = w;
				tppwm_pkg::ADDR_DUTY_B:    next_st.duty_b  = w;
				tppwm_pkg::ADDR_DUTY_C:    next_st.duty_c  = w;
				tppwm_pkg::ADDR_OUTCTRL:   next_st.outctl  = w & tppwm_pkg::OUT_MASK; // RL22
				tppwm_pkg::ADDR_SYNCWIDTH: next_st.swidth  = w & tppwm_pkg::TEN_BIT_MASK; // RL21
				default: ;
			endcase
		end
		// Flag clears by writing one; a same-cycle set below still wins.
		if (bus.wr && bus.addr == tppwm_pkg::ADDR_STATUS) begin
			if (w[tppwm_pkg::STA_SYNC_FLAG]) next_st.sync_flag = 1'b0; // RL6
			if (w[tppwm_pkg::STA_TRIP_FLAG]) next_st.trip_flag = 1'b0; // RL7
		end
		// Period timer counts down in the first half, up in the second.
		// A trip or a cleared enable parks it at the period, ready for a clean restart.
		if (!st.control[tppwm_pkg::CTL_ENABLE] || tripped) begin
			next_st.timer = st.period;
			next_st.dir   = tppwm_pkg::TPPWM_DOWN;
		end else if (boundary) begin
			next_st.timer = st.period;
			next_st.dir   = tppwm_pkg::TPPWM_DOWN;
		end else if (st.dir == tppwm_pkg::TPPWM_DOWN) begin
			if (st.timer == 16'h0000) next_st.dir = tppwm_pkg::TPPWM_UP; // RL9
			else next_st.timer = st.timer - 16'h0001;
		end else if (st.timer < st.period) begin
			next_st.timer = st.timer + 16'h0001;
		end
		// Sync pulse lasting the programmed width plus one cycle, suppressed while tripped or when sync is off.
		if (boundary && st.control[tppwm_pkg::CTL_ENABLE] && !tripped
			&& st.control[tppwm_pkg::CTL_SYNC_EN]) begin // RL2
			next_st.sync_pulse = 1'b1;
			next_st.sync_cnt   = st.swidth[9:0];
			next_st.sync_flag  = 1'b1; // RL23
		end else if (st.sync_cnt != 10'h000 && !tripped) begin
			next_st.sync_cnt = st.sync_cnt - 10'h001;
		end else begin
			next_st.sync_pulse = 1'b0;
		end
		// Output control takes effect only at update points.
		if (latch_now) next_st.outctl_act = st.outctl; // RL17
		// Chop carrier toggles every half carrier period.
		// It runs free, so the first chopped pulse after enable may be short.
		if (st.chop_cnt >= chop_limit) begin
			next_st.chop_cnt = 10'h000;
			next_st.chop_clk = ~st.chop_clk;
		end else begin
			next_st.chop_cnt = st.chop_cnt + 10'h001;
		end
		// Disable bits 5..0 map to 0L,0H,1L,1H,2L,2H; rearrange to phase order.
		dis = {st.outctl_act[0], st.outctl_act[1], st.outctl_act[2],
			st.outctl_act[3], st.outctl_act[4], st.outctl_act[5]};
		g = routed & ~dis; // RL15 RL16
		for (int i = 0; i < 3; i++) begin
			if (st.chopcfg[tppwm_pkg::CFG_LO_CHOP]) g[2*i]   = g[2*i] & st.chop_clk; // RL10
			if (st.chopcfg[tppwm_pkg::CFG_HI_CHOP]) g[2*i+1] = g[2*i+1] & st.chop_clk; // RL10
		end
		if (!st.control[tppwm_pkg::CTL_ENABLE] || tripped) g = 6'h00;
		next_st.gate = g;
		// Trip clears the enable and raises the trip flag.
		if (tripped && st.control[tppwm_pkg::CTL_ENABLE]) begin
			next_st.control[tppwm_pkg::CTL_ENABLE] = 1'b0; // RL1
			next_st.trip_flag = 1'b1; // RL23
		end
	end

	// State register; everything resets to zero.
	// The asynchronous clear keeps the gates off even before the clock starts.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_out = st.rdata;
	assign gate_out  = st.gate;
	assign sync_out  = st.sync_pulse;

	// Checks on the block's own behaviour. They watch the registered state, so a
	// consequent lands one edge after the cycle that decides it, except in AST_SYNC_FLAG.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// Trip handling: enable drops, the flag rises, gates and sync go quiet.
	AST_TRIP_CLEARS_EN: assert property ( // RL1
		tripped && st.control[0] |=> !st.control[0] && st.trip_flag)
		else $error("trip did not clear enable");
	AST_GATES_OFF_TRIP: assert property ( // RL16
		tripped |=> gate_out == 6'h00)
		else $error("gates on during trip");
	AST_SYNC_OFF_TRIP: assert property ( // RL1
		tripped |=> !sync_out)
		else $error("sync pulse during trip");

	// Sync pulse generation and its interrupt flag.
	AST_NO_SYNC_WHEN_OFF: assert property ( // RL2
		!st.control[1] |=> !$rose(st.sync_pulse))
		else $error("sync pulse while sync disabled");
	AST_SYNC_FLAG: assert property ( // RL23
		$rose(st.sync_pulse) |-> st.sync_flag)
		else $error("sync flag not set");

	// Write-one-to-clear flags; a set in the same cycle is allowed to win.
	AST_W1C_SYNC: assert property ( // RL6
		wr_in && addr_in == tppwm_pkg::ADDR_STATUS && wdata_in[9]
		&& !(boundary && st.control[0] && st.control[1] && !tripped)
		|=> !st.sync_flag)
		else $error("sync flag not cleared");
	AST_W0_KEEPS_TRIP: assert property ( // RL7
		wr_in && addr_in == tppwm_pkg::ADDR_STATUS && !wdata_in[8] && st.trip_flag
		|=> st.trip_flag)
		else $error("trip flag lost");

	// Read data: the upper half is zero, status bits mirror the state one cycle back.
	AST_RESERVED_ZERO: assert property ( // RL22
		rd_in |=> rdata_out[31:16] == 16'h0000)
		else $error("reserved bits nonzero");
	AST_PHASE_BIT: assert property ( // RL9
		rd_in && addr_in == tppwm_pkg::ADDR_STATUS
		|=> rdata_out[0] == ($past(st.dir) == tppwm_pkg::TPPWM_DOWN))
		else $error("phase bit wrong");
	AST_TRIP_PIN_BIT: assert property ( // RL8
		rd_in && addr_in == tppwm_pkg::ADDR_STATUS
		|=> rdata_out[3] == $past(st.trip_sy[1]))
		else $error("trip pin bit wrong");

	// Output control: disables win over duty, swap routes the pair crosswise.
	AST_DISABLED_OFF: assert property ( // RL15
		st.outctl_act[5] |=> !gate_out[0])
		else $error("disabled output active");
	AST_HIGH_DISABLED_OFF: assert property ( // RL15
		st.outctl_act[4] |=> !gate_out[1])
		else $error("disabled high output active");
	AST_SWAP_ROUTE: assert property ( // RL14
		st.outctl_act[8] && !st.outctl_act[5] && st.control[0] && !tripped && !st.chopcfg[9]
		|=> gate_out[0] == $past(raw[1]))
		else $error("swapped low pin not fed by high side");
	AST_NO_SWAP_PASS: assert property ( // RL14
		!st.outctl_act[8] && !st.outctl_act[5] && st.control[0] && !tripped && !st.chopcfg[9]
		|=> gate_out[0] == $past(raw[0]))
		else $error("unswapped low pin not fed by low side");

	// Update points: outside them the active copy holds; double mode loads it mid-cycle.
	AST_LATCH_HOLD: assert property ( // RL17
		!latch_now |=> st.outctl_act == $past(st.outctl_act))
		else $error("output control changed off boundary");
	AST_DOUBLE_MID: assert property ( // RL3
		st.control[2] && st.dir == tppwm_pkg::TPPWM_DOWN && st.timer == 16'h0000
		|=> st.outctl_act == $past(st.outctl))
		else $error("no mid-cycle update in double mode");

	// The chop carrier wraps and toggles at its half period.
	AST_CHOP_WRAP: assert property ( // RL12
		st.chop_cnt >= chop_limit
		|=> st.chop_cnt == 10'h000 && st.chop_clk != $past(st.chop_clk))
		else $error("chop carrier did not wrap");

	// Main scenarios that the bench is expected to reach.
	COV_SYNC: cover property (
		$rose(sync_out));
	COV_TRIP: cover property (
		$fell(st.control[0]) && st.trip_flag);
	COV_SWAP: cover property (
		st.outctl_act[8] && gate_out[0]);
	COV_DOUBLE: cover property (
		st.control[2] && latch_now && !boundary);
	COV_EXT_SYNC: cover property (
		st.control[4] && $rose(sync_out));

endmodule : tppwm_core

/* File: tppwm_gate_drv_model.sv */
// Behavioural model of the fault source and external sync source on the pin side.
`timescale 1ns/1ps

module tppwm_gate_drv_model (
	// Clock.
	input  wire logic clk_in,
	// Commands from the bench.
	input  wire logic fault_in,
	input  wire logic pulse_in,
	// Pins toward the block.
	output logic      trip_n_out,
	output logic      ext_sync_out
);
	// A fault pulls the line low, just as the pull-down does on an open pin.
	assign trip_n_out = !fault_in;
	// The external sync is one core cycle wide and launched just after an edge.
	always_ff @(posedge clk_in) begin
		ext_sync_out <= pulse_in;
	end
endmodule : tppwm_gate_drv_model

/* File: tppwm_core_test.sv */
// Self-checking bench for the three-phase PWM register block.
`timescale 1ns/1ps

module tppwm_core_test;
	// Clock, reset and register port.
	logic        clk_in;
	logic        rst_n_in;
	logic [31:0] addr_in;
	logic [31:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rdata_out;
	// Pins and model commands.
	logic        trip_n_in;
	logic        ext_sync_in;
	logic  [5:0] gate_out;
	logic        sync_out;
	logic        fault;
	logic        pulse;
	// Bench state.
	int          n_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          k;
	logic [31:0] d;
	logic  [6:0] m;
	localparam logic [31:0] CTL = tppwm_pkg::ADDR_CONTROL;
	localparam logic [31:0] STA = tppwm_pkg::ADDR_STATUS;
	localparam logic [31:0] OUTC = tppwm_pkg::ADDR_OUTCTRL;
	// Register map, writable masks and the run set-up, in one order.
	localparam logic [31:0] MAP [9] = '{CTL, tppwm_pkg::ADDR_PERIOD, tppwm_pkg::ADDR_DEADTIME,
		tppwm_pkg::ADDR_CHOPCFG, tppwm_pkg::ADDR_DUTY_A, tppwm_pkg::ADDR_DUTY_B,
		tppwm_pkg::ADDR_DUTY_C, OUTC, tppwm_pkg::ADDR_SYNCWIDTH};
	localparam logic [31:0] MSK [9] = '{32'h1f, 32'hffff, 32'h3ff, 32'h3ff, 32'hffff,
		32'hffff, 32'hffff, 32'h1ff, 32'h3ff};
	localparam logic [31:0] SET [9] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h2};
	// Output control values and the gate and sync levels each lets through.
	localparam logic [31:0] OV [4] = '{32'h0, 32'h1c0, 32'h1d1, 32'h20};
	localparam logic [6:0] OM [4] = '{7'h55, 7'h6a, 7'h48, 7'h54};

	tppwm_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.trip_n_in(trip_n_in), .ext_sync_in(ext_sync_in), .gate_out(gate_out),
		.sync_out(sync_out));
	tppwm_gate_drv_model drv (.clk_in(clk_in), .fault_in(fault), .pulse_in(pulse),
		.trip_n_out(trip_n_in), .ext_sync_out(ext_sync_in));

	// Free-running core clock.
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// A hang is cut short well beyond the roughly one thousand cycles the run needs.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	// Bus cycles hold every signal for the whole strobe cycle.
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1 d = rdata_out;
	endtask : rd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// Collects every level seen on the gates and sync output over n cycles.
	task automatic obs(input int n);
		m = '0;
		repeat (n) begin
			@(posedge clk_in) #1;
			m = m | {sync_out, gate_out};
		end
	endtask : obs

	// Waits for a fresh rising edge of the sync output, bounded.
	task automatic wait_sync;
		for (k = 0; k < 400 && sync_out !== 1'b0; k++) @(posedge clk_in) #1;
		for (k = 0; k < 400 && sync_out !== 1'b1; k++) @(posedge clk_in) #1;
		chk("sync_out", 32'h1, {31'h0, sync_out});
	endtask : wait_sync

	// Advances until gate 0L reaches a level, adding the cycles spent to k.
	task automatic until_gate(input logic lvl);
		for (int i = 0; i < 50 && gate_out[0] !== lvl; i++) begin
			@(posedge clk_in) #1;
			k++;
		end
	endtask : until_gate

	task automatic end_of_test;
		if (n_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Main sequence.
	initial begin
		rst_n_in = 1'b0;
		addr_in = '0;
		wdata_in = '0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		fault = 1'b0;
		pulse = 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd(MAP[i]);
			chk("reset value", 32'h0, d);
		end
		rd(STA);
		chk("status after reset", 32'h9, d);
		for (int i = 0; i < 9; i++) begin
			wr(MAP[i], 32'hffffffff);
			rd(MAP[i]);
			chk("masked readback", MSK[i], d);
		end
		wr(STA, 32'hffffffff);
		rd(STA);
		chk("status reserved", 32'h0, d & 32'hfffffcf6);
		wr(32'hfffffc28, 32'hffff);
		rd(32'hfffffc28);
		chk("unmapped read", 32'h0, d);
		// Short period, no dead time, zero duty: high sides off, low sides on.
		for (int i = 0; i < 9; i++) wr(MAP[i], SET[i]);
		wr(CTL, 32'h3);
		wait_sync();
		for (k = 0; sync_out === 1'b1 && k < 100; k++) @(posedge clk_in) #1;
		chk("sync width", 32'(k), 32'd3);
		rd(STA);
		chk("sync flag", 32'h200, d & 32'h200);
		wr(STA, 32'h0);
		rd(STA);
		chk("sync flag kept", 32'h200, d & 32'h200);
		wr(STA, 32'h200);
		rd(STA);
		chk("sync flag cleared", 32'h0, d & 32'h200);
		m = '0;
		for (int i = 0; i < 40; i++) begin
			rd(STA);
			m[d[0]] = 1'b1;
		end
		chk("phase bit values", 32'h3, {30'h0, m[1:0]});
		// Swap and disable settings only take hold at a cycle boundary.
		for (int i = 0; i < 4; i++) begin
			wr(OUTC, OV[i]);
			wait_sync();
			wait_sync();
			obs(40);
			chk("gate levels", {25'h0, OM[i]}, {25'h0, m});
		end
		// Double update: a write just after sync already takes hold at the midpoint.
		wr(CTL, 32'h7);
		wait_sync();
		wr(OUTC, 32'h0);
		repeat (18) @(posedge clk_in);
		obs(8);
		chk("mid-cycle latch", 32'h15, {25'h0, m});
		wr(tppwm_pkg::ADDR_CHOPCFG, 32'h201);
		until_gate(1'b0);
		until_gate(1'b1);
		k = 0;
		until_gate(1'b0);
		until_gate(1'b1);
		chk("chop period", 32'd8, 32'(k));
		wr(tppwm_pkg::ADDR_CHOPCFG, 32'h0);
		// External sync, first taken as synchronous, then through the resynchroniser.
		for (int j = 0; j < 2; j++) begin
			wr(CTL, (j == 0) ? 32'h1b : 32'h13);
			repeat (5) @(posedge clk_in);
			obs(100);
			chk("internal sync ignored", 32'h0, {31'h0, m[6]});
			@(posedge clk_in);
			pulse <= 1'b1;
			@(posedge clk_in);
			pulse <= 1'b0;
			for (k = 0; k < 10 && sync_out !== 1'b1; k++) @(posedge clk_in) #1;
			chk("external sync", 32'h1, {31'h0, sync_out});
		end
		wr(CTL, 32'h3);
		@(posedge clk_in);
		fault <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1 chk("gates on trip", 32'h0, {26'h0, gate_out});
		rd(STA);
		chk("trip flag and pin", 32'h100, d & 32'h108);
		rd(CTL);
		chk("enable after trip", 32'h0, d & 32'h1);
		wr(STA, 32'h0);
		rd(STA);
		chk("trip flag kept", 32'h100, d & 32'h100);
		wr(STA, 32'h100);
		rd(STA);
		chk("trip flag cleared", 32'h0, d & 32'h100);
		end_of_test();
	end
endmodule : tppwm_core_test
